// >>> bench/lcd_monitor_out_and_display_ram_bench.sv
`timescale 1ns/1ps
module lcd_monitor_out_and_display_ram_bench;
  logic sys_clk = 1'b0, rstn = 1'b0, srcTick = 1'b0, tickRun = 1'b0, dispCheck = 1'b0;
  logic [1:0] timingSourceSelect = 2'h0, tickDiv = 2'h0;
  logic panelDriverOn = 0, screenAreaSelect = 0, columnMapReverse = 0, rowMapReverse = 0;
  logic linePulsePinEnable = 0, framePinEnable = 0, port2Bit6Data = 0, port2Bit6Dir = 0;
  logic port2Bit7Data = 0, port2Bit7Dir = 0, ext6On = 0, ext7On = 0, ext6Val = 0, ext7Val = 0;
  logic port2Bit6In, port2Bit7In, port2Bit6Out, port2Bit6Oe, port2Bit7Out, port2Bit7Oe;
  logic port2Bit6Level, port2Bit7Level, cpuRead = 0, cpuWrite = 0, cpuRdValid, ramSelect;
  logic extBusEnable, linePulse, polarityToggle, boostTick, lineLoad, lpHold, frHold;
  logic [15:0]  cpuAddr = 16'h0000;
  logic [7:0]   cpuWrData = 8'h00, cpuRdData;
  logic [127:0] segOut;
  logic [5:0]   comSel, lastCom = 6'h00;
  logic [31:0]  lfsrState = 32'h1622_eea8;
  logic [15:0]  edgeAddr [6] = '{16'hE800, 16'hEF7F, 16'hDFFF, 16'hEF80, 16'h0000, 16'hFFFF};
  int failures = 0, compares = 0, cycles = 0, ticks = 0, t0, boosts = 0, b0;
  int mem [0:2047];

  lcd_monitor_out_and_display_ram u_dut (
    .sys_clk(sys_clk), .rstn(rstn), .srcTick(srcTick), .timingSourceSelect(timingSourceSelect),
    .panelDriverOn(panelDriverOn), .screenAreaSelect(screenAreaSelect),
    .columnMapReverse(columnMapReverse), .rowMapReverse(rowMapReverse),
    .linePulsePinEnable(linePulsePinEnable), .framePinEnable(framePinEnable),
    .port2Bit6Data(port2Bit6Data), .port2Bit6Dir(port2Bit6Dir), .port2Bit7Data(port2Bit7Data),
    .port2Bit7Dir(port2Bit7Dir), .port2Bit6In(port2Bit6In), .port2Bit7In(port2Bit7In),
    .port2Bit6Out(port2Bit6Out), .port2Bit6Oe(port2Bit6Oe), .port2Bit7Out(port2Bit7Out),
    .port2Bit7Oe(port2Bit7Oe), .port2Bit6Level(port2Bit6Level), .port2Bit7Level(port2Bit7Level),
    .cpuAddr(cpuAddr), .cpuRead(cpuRead), .cpuWrite(cpuWrite), .cpuWrData(cpuWrData),
    .cpuRdData(cpuRdData), .cpuRdValid(cpuRdValid), .ramSelect(ramSelect),
    .extBusEnable(extBusEnable), .linePulse(linePulse), .polarityToggle(polarityToggle),
    .boostTick(boostTick), .segOut(segOut), .comSel(comSel), .lineLoad(lineLoad));
  lcd_pin_partner u_pin6 (.oe(port2Bit6Oe), .drv(port2Bit6Out), .extOn(ext6On),
                          .extVal(ext6Val), .pin(port2Bit6In));
  lcd_pin_partner u_pin7 (.oe(port2Bit7Oe), .drv(port2Bit7Out), .extOn(ext7On),
                          .extVal(ext7Val), .pin(port2Bit7In));

  always #2.5 sys_clk = ~sys_clk;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task summarize();
    if (failures == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Source clock: one pulse every fourth cycle leaves room for the line fetch
  always @(negedge sys_clk) begin
    tickDiv <= tickDiv + 2'h1;
    srcTick <= tickRun && (tickDiv == 2'h3);
  end

  always @(posedge sys_clk) begin
    cycles++;
    if (srcTick) ticks++;
    if (boostTick === 1'b1) boosts++;
    if (cycles == 30000) begin
      failures++;
      summarize();
    end
  end

  function automatic logic [127:0] expSeg(input logic [5:0] com);
    logic [127:0] e;
    int row;
    int pos;
    row = rowMapReverse ? 63 - com : com;
    for (int b = 0; b < 128; b++) begin
      pos = columnMapReverse ? 127 - b : b;
      e[pos] = mem[screenAreaSelect * 1024 + row * 16 + b / 8][b % 8];
    end
    return e;
  endfunction

  always @(posedge sys_clk) if (lineLoad === 1'b1) begin
    if (dispCheck) check(segOut, expSeg(comSel));
    if (dispCheck) check(comSel, 6'(lastCom + 6'h01));
    lastCom = comSel;
  end

  task automatic cpu(input logic wr, input logic [15:0] a, input logic [7:0] d);
    logic inRange;
    inRange = a >= 16'hE000 && a <= 16'hEF7F;
    @(negedge sys_clk);
    cpuAddr = a;
    cpuWrData = d;
    cpuWrite = wr;
    cpuRead = !wr;
    @(negedge sys_clk);
    cpuWrite = 1'b0;
    cpuRead = 1'b0;
    check({extBusEnable, ramSelect}, {!inRange, inRange});
    check(cpuRdValid, !wr && inRange);
    if (!wr && inRange) check(cpuRdData, a < 16'hE800 ? mem[a - 16'hE000] & 8'hFF : 0);
    if (wr && inRange && a < 16'hE800) mem[a - 16'hE000] = d;
  endtask

  task automatic waitLoads(input int n);
    repeat (n) begin
      @(posedge sys_clk);
      while (lineLoad !== 1'b1) @(posedge sys_clk);
    end
  endtask

  initial begin
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    check({port2Bit6Out, port2Bit6Oe, port2Bit7Out, port2Bit7Oe, linePulse, polarityToggle,
           boostTick, lineLoad, cpuRdValid, ramSelect, extBusEnable}, 11'h000);
    rstn = 1'b1;
    for (int i = 0; i < 2048; i++) begin
      lfsrState = lfsr(lfsrState);
      cpu(1'b1, 16'hE000 + 16'(i), lfsrState[7:0]);
    end
    for (int i = 0; i < 32; i++) begin
      lfsrState = lfsr(lfsrState);
      cpu(1'b0, 16'hE000 + 16'(lfsrState[10:0]), 8'h00);
    end
    foreach (edgeAddr[i]) begin
      cpu(1'b1, edgeAddr[i], 8'h5A);
      cpu(1'b0, edgeAddr[i], 8'h00);
    end
    // Write then read the same byte on the next edge
    @(negedge sys_clk);
    cpuAddr = 16'hE3A5;
    cpuWrData = 8'hC3;
    cpuWrite = 1'b1;
    @(negedge sys_clk);
    cpuWrite = 1'b0;
    cpuRead = 1'b1;
    @(negedge sys_clk);
    cpuRead = 1'b0;
    check(cpuRdValid, 1'b1);
    check(cpuRdData, 8'hC3);
    mem[16'h03A5] = 8'hC3;
    @(negedge sys_clk);
    timingSourceSelect = 2'h1;
    panelDriverOn = 1'b1;
    tickRun = 1'b1;
    @(posedge linePulse);
    t0 = ticks;
    b0 = boosts;
    @(posedge linePulse);
    check(ticks - t0, 8);
    check(boosts - b0, 8);
    @(polarityToggle);
    t0 = ticks;
    @(polarityToggle);
    check(ticks - t0, 512);
    for (int m = 0; m < 8; m++) begin
      @(negedge sys_clk);
      {screenAreaSelect, columnMapReverse, rowMapReverse} = 3'(m);
      waitLoads(2);
      @(negedge sys_clk) dispCheck = 1'b1;
      waitLoads(3);
      @(negedge sys_clk) dispCheck = 1'b0;
    end
    // Pins get new random enables every fifth cycle; glitches are tolerated
    for (int i = 0; i < 64; i++) begin
      @(negedge sys_clk);
      lfsrState = lfsr(lfsrState);
      {linePulsePinEnable, framePinEnable, port2Bit6Data, port2Bit6Dir, port2Bit7Data,
       port2Bit7Dir, ext6On, ext7On, ext6Val, ext7Val} = lfsrState[9:0];
      lpHold = linePulse;
      frHold = polarityToggle;
      @(negedge sys_clk);
      check(port2Bit6Oe, linePulsePinEnable | port2Bit6Dir);
      check(port2Bit7Oe, framePinEnable | port2Bit7Dir);
      if (linePulse === lpHold && (linePulsePinEnable | port2Bit6Dir))
        check(port2Bit6Out, linePulsePinEnable ? linePulse : port2Bit6Data);
      if (polarityToggle === frHold && (framePinEnable | port2Bit7Dir))
        check(port2Bit7Out, framePinEnable ? polarityToggle : port2Bit7Data);
      // Level shows the pin three edges late; released pins float high
      repeat (3) @(negedge sys_clk);
      if (!linePulsePinEnable)
        check(port2Bit6Level, port2Bit6Dir ? port2Bit6Data : (!ext6On | ext6Val));
      if (!framePinEnable)
        check(port2Bit7Level, port2Bit7Dir ? port2Bit7Data : (!ext7On | ext7Val));
    end
    @(negedge sys_clk) timingSourceSelect = 2'h0;
    repeat (4) @(negedge sys_clk);
    lpHold = linePulse;
    repeat (64) @(negedge sys_clk) begin
      check(boostTick, 1'b0);
      check(linePulse, lpHold);
    end
    timingSourceSelect = 2'h3;
    panelDriverOn = 1'b0;
    repeat (4) @(negedge sys_clk);
    frHold = polarityToggle;
    repeat (64) @(negedge sys_clk) begin
      check(linePulse, 1'b0);
      check(polarityToggle, frHold);
    end
    summarize();
  end
endmodule // lcd_monitor_out_and_display_ram_bench

// >>> bench/lcd_pin_partner.sv
`timescale 1ns/1ps
module lcd_pin_partner (
  input  wire logic oe,     // Device drives the pin
  input  wire logic drv,    // Device drive value
  input  wire logic extOn,  // Probe drives the pin
  input  wire logic extVal, // Probe drive value
  output logic      pin     // Resolved pin level
);
  // Device wins a clash; pull-up keeps a released line high
  assign pin = oe ? drv : (extOn ? extVal : 1'b1);
endmodule // lcd_pin_partner

// >>> verilog/lcd_display_ram.sv
`timescale 1ns/1ps
module lcd_display_ram #(
  parameter int DEPTH  = lcd_pkg::RAM_BYTES,
  parameter int ADDR_W = lcd_pkg::RAM_ADDR_W
) (
  input  wire logic              sys_clk,   // System clock
  input  wire logic              cpuWrite,  // CPU write strobe
  input  wire logic [ADDR_W-1:0] cpuIndex,  // CPU byte index
  input  wire logic [7:0]        cpuWrData, // CPU write data
  output logic      [7:0]        cpuRdData, // CPU read data, combinational
  input  wire logic [ADDR_W-1:0] dispIndex, // Display fetch index
  output logic      [7:0]        dispData   // Display data, one cycle late
);

  // Contents are not reset; software fills the screen before enabling
  logic [7:0] mem [DEPTH];

  always_ff @(posedge sys_clk) begin
    if (cpuWrite) begin
      mem[cpuIndex] <= cpuWrData;
    end
    dispData  <= mem[dispIndex];
  end

  // Read through, so the top registers the byte together with its valid pulse
  assign cpuRdData = mem[cpuIndex];

endmodule // lcd_display_ram

// >>> verilog/lcd_monitor_out_and_display_ram.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Line pulse enable puts the line clock on port 2 bit 6.
// - Frame pin enable puts the polarity signal on port 2 bit 7.
// - While enabled, that pin ignores its data and direction settings.
// - Enable low returns the pin to normal data and direction control.
// - Enable switching is not synchronised; glitches on the pin are allowed.
// - Line and polarity signals run only while the panel driver is on.
// - 2K bytes of screen memory, two screens, mapped at E000 to EF7F.
// - Area select 0 shows screen 0, 1 shows screen 1.
// - Column reverse flips segment order, row reverse flips common order.
// - A stored 1 lights the dot, 0 leaves it dark.
// - CPU reads return stored bytes so read-modify-write works.
// - Accesses in the screen range stay internal, never go off chip.
// - Line clock is source divided by 8, frame is line by 64.
// - Source select 00 stops the generator and the booster clock.
module lcd_monitor_out_and_display_ram (
  input  wire logic         sys_clk,            // 200 MHz system clock
  input  wire logic         rstn,               // Async reset, active low
  input  wire logic         srcTick,            // Selected source clock enable
  input  wire logic [1:0]   timingSourceSelect, // Timing source, 00 = off
  input  wire logic         panelDriverOn,      // Panel driver enable
  input  wire logic         screenAreaSelect,   // Displayed screen area
  input  wire logic         columnMapReverse,   // Reverse segment order
  input  wire logic         rowMapReverse,      // Reverse common order
  input  wire logic         linePulsePinEnable, // Line clock onto bit 6 pin
  input  wire logic         framePinEnable,     // Polarity onto bit 7 pin
  input  wire logic         port2Bit6Data,      // Port data for bit 6
  input  wire logic         port2Bit6Dir,       // 1 = bit 6 output
  input  wire logic         port2Bit7Data,      // Port data for bit 7
  input  wire logic         port2Bit7Dir,       // 1 = bit 7 output
  input  wire logic         port2Bit6In,        // Bit 6 pin level
  input  wire logic         port2Bit7In,        // Bit 7 pin level
  output logic              port2Bit6Out,       // Bit 6 pin drive value
  output logic              port2Bit6Oe,        // Bit 6 pin drive enable
  output logic              port2Bit7Out,       // Bit 7 pin drive value
  output logic              port2Bit7Oe,        // Bit 7 pin drive enable
  output logic              port2Bit6Level,     // Synchronised bit 6 level
  output logic              port2Bit7Level,     // Synchronised bit 7 level
  input  wire logic [15:0]  cpuAddr,            // CPU address
  input  wire logic         cpuRead,            // CPU read strobe
  input  wire logic         cpuWrite,           // CPU write strobe
  input  wire logic [7:0]   cpuWrData,          // CPU write data
  output logic [7:0]        cpuRdData,          // Read data for screen range
  output logic              cpuRdValid,         // Read data valid pulse
  output logic              ramSelect,          // Access served internally
  output logic              extBusEnable,       // Access forwarded off chip
  output logic              linePulse,          // Line clock
  output logic              polarityToggle,     // Frame polarity
  output logic              boostTick,          // Booster clock enable
  output logic [127:0]      segOut,             // Dot states of one line
  output logic [5:0]        comSel,             // Common driven by segOut
  output logic              lineLoad            // Pulse when segOut updates
);

  localparam int AW = lcd_pkg::RAM_ADDR_W;

  // Timing generator
  logic       tgLine;
  logic       tgFrame;
  logic       tgStart;
  logic [5:0] tgLineIdx;
  logic       tgBoost;

  lcd_timing_gen u_timing (
    .sys_clk        (sys_clk),
    .rstn           (rstn),
    .srcTick        (srcTick),
    .srcSelect      (timingSourceSelect),
    .driverOn       (panelDriverOn),
    .linePulse      (tgLine),
    .polarityToggle (tgFrame),
    .lineStart      (tgStart),
    .lineIdx        (tgLineIdx),
    .boostTick      (tgBoost)
  );

  // CPU decode
  wire [15:0] cpuOffset = cpuAddr - lcd_pkg::RAM_FIRST_ADDR;
  wire        inRange   = (cpuAddr >= lcd_pkg::RAM_FIRST_ADDR) &&
                          (cpuAddr <= lcd_pkg::RAM_LAST_ADDR);
  // Upper part of the window holds no storage: reads zero, writes dropped
  wire        ramHit    = inRange && (cpuOffset < 16'(lcd_pkg::RAM_BYTES));
  wire        anyAccess = cpuRead || cpuWrite;
  wire [AW-1:0] cpuIndex = cpuOffset[AW-1:0];
  wire        ramWrite  = cpuWrite && ramHit;

  // Display fetch
  logic [1:0]             scanState_r;
  lcd_pkg::scan_state_t   scanState;
  lcd_pkg::scan_state_t   scanState_nxt;
  logic [3:0]             byteCnt_r;
  logic [3:0]             dataByte_r;
  logic                   dataValid_r;
  logic [5:0]             scanCom_r;
  logic [127:0]           lineBuf_r;
  wire  [7:0]             dispData;
  wire  [7:0]             ramRdData;

  assign scanState = lcd_pkg::scan_state_t'(scanState_r);

  wire [5:0] scanRow = rowMapReverse ? (lcd_pkg::COM_LAST - scanCom_r) : scanCom_r;
  wire [AW-1:0] dispIndex = {screenAreaSelect, scanRow, byteCnt_r};

  lcd_display_ram u_ram (
    .sys_clk   (sys_clk),
    .cpuWrite  (ramWrite),
    .cpuIndex  (cpuIndex),
    .cpuWrData (cpuWrData),
    .cpuRdData (ramRdData),
    .dispIndex (dispIndex),
    .dispData  (dispData)
  );

  // Fetch takes 19 cycles: source ticks must be at least 3 cycles apart
  always_comb begin
    scanState_nxt = scanState;
    unique case (scanState)
      lcd_pkg::SCAN_IDLE:  if (tgStart) scanState_nxt = lcd_pkg::SCAN_FETCH;
      lcd_pkg::SCAN_FETCH: if (byteCnt_r == 4'hF) scanState_nxt = lcd_pkg::SCAN_LATCH;
      lcd_pkg::SCAN_LATCH: if (!dataValid_r) scanState_nxt = lcd_pkg::SCAN_IDLE;
    endcase
  end

  // Byte k bit j sits on segment 8k+j, or on 127-(8k+j) reversed
  wire [127:0] lineBuf_nxt;
  genvar gs;
  generate
    for (gs = 0; gs < lcd_pkg::SEG_COUNT; gs++) begin : g_seg
      wire [6:0] segPos = columnMapReverse ? (7'h7F - 7'(gs)) : 7'(gs);
      wire       segHit = dataValid_r && (segPos[6:3] == dataByte_r);
      assign lineBuf_nxt[gs] = segHit ? dispData[segPos[2:0]] : lineBuf_r[gs];
    end
  endgenerate

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      scanState_r <= 2'(lcd_pkg::SCAN_IDLE);
      byteCnt_r   <= 4'h0;
      dataByte_r  <= 4'h0;
      dataValid_r <= 1'b0;
      scanCom_r   <= lcd_pkg::LINE_RESET;
      lineBuf_r   <= '0;
    end else begin
      scanState_r <= 2'(scanState_nxt);
      dataValid_r <= (scanState == lcd_pkg::SCAN_FETCH);
      dataByte_r  <= byteCnt_r;
      if (scanState == lcd_pkg::SCAN_IDLE && tgStart) begin
        scanCom_r <= tgLineIdx;
        byteCnt_r <= 4'h0;
      end else if (scanState == lcd_pkg::SCAN_FETCH) begin
        byteCnt_r <= byteCnt_r + 4'h1;
      end
      if (dataValid_r) begin
        lineBuf_r <= lineBuf_nxt;
      end
    end
  end

  // Output registers
  logic [1:0] sync6_r;
  logic [1:0] sync7_r;
  logic       latchDone;
  assign latchDone = (scanState == lcd_pkg::SCAN_LATCH) && !dataValid_r;

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      port2Bit6Out   <= 1'b0;
      port2Bit6Oe    <= 1'b0;
      port2Bit7Out   <= 1'b0;
      port2Bit7Oe    <= 1'b0;
      sync6_r        <= 2'b00;
      sync7_r        <= 2'b00;
      port2Bit6Level <= 1'b0;
      port2Bit7Level <= 1'b0;
      cpuRdValid     <= 1'b0;
      ramSelect      <= 1'b0;
      extBusEnable   <= 1'b0;
      cpuRdData      <= lcd_pkg::BYTE_RESET;
      linePulse      <= 1'b0;
      polarityToggle <= 1'b0;
      boostTick      <= 1'b0;
      segOut         <= '0;
      comSel         <= lcd_pkg::LINE_RESET;
      lineLoad       <= 1'b0;
    end else begin
      // Plain mux on the enable; glitches when toggled are accepted
      port2Bit6Out   <= linePulsePinEnable ? tgLine : port2Bit6Data;
      port2Bit6Oe    <= linePulsePinEnable ? 1'b1 : port2Bit6Dir;
      port2Bit7Out   <= framePinEnable ? tgFrame : port2Bit7Data;
      port2Bit7Oe    <= framePinEnable ? 1'b1 : port2Bit7Dir;
      sync6_r        <= {sync6_r[0], port2Bit6In};
      sync7_r        <= {sync7_r[0], port2Bit7In};
      port2Bit6Level <= sync6_r[1];
      port2Bit7Level <= sync7_r[1];
      cpuRdValid     <= cpuRead && inRange;
      ramSelect      <= anyAccess && inRange;
      extBusEnable   <= anyAccess && !inRange;
      cpuRdData      <= ramHit ? ramRdData : lcd_pkg::BYTE_RESET;
      linePulse      <= tgLine;
      polarityToggle <= tgFrame;
      boostTick      <= tgBoost;
      lineLoad       <= latchDone;
      if (latchDone) begin
        segOut <= lineBuf_r;
        comSel <= scanCom_r;
      end
    end
  end

  property p_line_pin;
    @(posedge sys_clk) disable iff (!rstn)
      linePulsePinEnable |=> port2Bit6Oe && port2Bit6Out == $past(tgLine);
  endproperty
  a_line_pin: assert property (p_line_pin) else $error("Bit 6 not showing line clock");

  property p_frame_pin;
    @(posedge sys_clk) disable iff (!rstn)
      framePinEnable |=> port2Bit7Oe && port2Bit7Out == $past(tgFrame);
  endproperty
  a_frame_pin: assert property (p_frame_pin) else $error("Bit 7 not showing polarity");

  property p_port_normal;
    @(posedge sys_clk) disable iff (!rstn)
      (!linePulsePinEnable && !framePinEnable) |=>
        port2Bit6Out == $past(port2Bit6Data) && port2Bit6Oe == $past(port2Bit6Dir) &&
        port2Bit7Out == $past(port2Bit7Data) && port2Bit7Oe == $past(port2Bit7Dir);
  endproperty
  a_port_normal: assert property (p_port_normal) else $error("Port not under its registers");

  property p_internal;
    @(posedge sys_clk) disable iff (!rstn)
      (anyAccess && inRange) |=> ramSelect && !extBusEnable;
  endproperty
  a_internal: assert property (p_internal) else $error("Screen access left the chip");

  property p_readback;
    @(posedge sys_clk) disable iff (!rstn)
      (cpuWrite && ramHit ##1 cpuRead && !cpuWrite && cpuAddr == $past(cpuAddr)) |=>
        cpuRdValid && cpuRdData == $past(cpuWrData, 2);
  endproperty
  a_readback: assert property (p_readback) else $error("Read did not return written byte");

  property p_com_map;
    @(posedge sys_clk) disable iff (!rstn)
      lineLoad |-> comSel == $past(scanCom_r);
  endproperty
  a_com_map: assert property (p_com_map) else $error("Common index mismatch");

  property p_outside;
    @(posedge sys_clk) disable iff (!rstn)
      (anyAccess && !inRange) |=> extBusEnable && !ramSelect;
  endproperty
  a_outside: assert property (p_outside) else $error("Outside access kept inside");

  property p_bus_quiet;
    @(posedge sys_clk) disable iff (!rstn)
      !anyAccess |=> !ramSelect && !extBusEnable;
  endproperty
  a_bus_quiet: assert property (p_bus_quiet) else $error("Select without access");

  property p_rd_valid;
    @(posedge sys_clk) disable iff (!rstn)
      (cpuRead && inRange) |=> cpuRdValid;
  endproperty
  a_rd_valid: assert property (p_rd_valid) else $error("Read not answered");

  property p_empty_part;
    @(posedge sys_clk) disable iff (!rstn)
      (cpuRead && inRange && !ramHit) |=> cpuRdData == lcd_pkg::BYTE_RESET;
  endproperty
  a_empty_part: assert property (p_empty_part) else $error("Empty window read not zero");

  property p_seg_hold;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(segOut) |-> lineLoad;
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("Segments moved without load");

  property p_fetch_len;
    @(posedge sys_clk) disable iff (!rstn)
      (scanState == lcd_pkg::SCAN_IDLE && tgStart) |-> ##19 lineLoad;
  endproperty
  a_fetch_len: assert property (p_fetch_len) else $error("Line not loaded after fetch");

  property p_load_pulse;
    @(posedge sys_clk) disable iff (!rstn)
      lineLoad |=> !lineLoad;
  endproperty
  a_load_pulse: assert property (p_load_pulse) else $error("Line load too long");

  property p_pin6_normal;
    @(posedge sys_clk) disable iff (!rstn)
      !linePulsePinEnable |=>
        port2Bit6Out == $past(port2Bit6Data) && port2Bit6Oe == $past(port2Bit6Dir);
  endproperty
  a_pin6_normal: assert property (p_pin6_normal) else $error("Bit 6 not under registers");

  property p_pin7_normal;
    @(posedge sys_clk) disable iff (!rstn)
      !framePinEnable |=>
        port2Bit7Out == $past(port2Bit7Data) && port2Bit7Oe == $past(port2Bit7Dir);
  endproperty
  a_pin7_normal: assert property (p_pin7_normal) else $error("Bit 7 not under registers");

endmodule // lcd_monitor_out_and_display_ram

// >>> verilog/lcd_pkg.sv
package lcd_pkg;

  // CPU address window of the display RAM
  localparam logic [15:0] RAM_FIRST_ADDR = 16'hE000;
  localparam logic [15:0] RAM_LAST_ADDR  = 16'hEF7F;

  // Storage geometry
  localparam int RAM_BYTES       = 2048;
  localparam int RAM_ADDR_W      = 11;
  localparam int SCREEN_BITS     = 8192;
  localparam int SEG_COUNT       = 128;
  localparam int COM_COUNT       = 64;
  localparam int ROW_BYTES       = 16;
  localparam int ROW_BYTE_W      = 4;
  localparam int COM_W           = 6;
  localparam logic [5:0] COM_LAST = 6'h3F;

  // Field positions inside the RAM index: {area, row, byte}
  localparam int AREA_BIT_POS    = 10;
  localparam int ROW_LSB_POS     = 4;

  // Divisions of the selected source clock
  localparam int CL_DIVIDE       = 8;
  localparam int FR_DIVIDE       = 64;
  localparam int TOTAL_DIVIDE    = 512;
  localparam int CL_CNT_W        = 3;
  localparam logic [2:0] CL_CNT_LAST = 3'h7;
  localparam int CL_HIGH_BIT     = 2;

  // Source select code that stops the timing generator
  localparam logic [1:0] SRC_OFF = 2'h0;

  // Reset values
  localparam logic [7:0] BYTE_RESET  = 8'h00;
  localparam logic [5:0] LINE_RESET  = 6'h00;
  localparam logic [2:0] CNT_RESET   = 3'h0;

  typedef enum logic [1:0] {SCAN_IDLE, SCAN_FETCH, SCAN_LATCH} scan_state_t;

endpackage

// >>> verilog/lcd_timing_gen.sv
`timescale 1ns/1ps
module lcd_timing_gen (
  input  wire logic       sys_clk,        // System clock
  input  wire logic       rstn,           // Async reset, active low
  input  wire logic       srcTick,        // One pulse per source clock period
  input  wire logic [1:0] srcSelect,      // Timing source select
  input  wire logic       driverOn,       // Panel driver enable
  output logic            linePulse,      // Line clock
  output logic            polarityToggle, // Frame polarity
  output logic            lineStart,      // Pulse at each new line
  output logic [5:0]      lineIdx,        // Current common line
  output logic            boostTick       // Booster clock enable
);

  logic [2:0] divCnt_r;
  logic [5:0] lineIdx_r;
  logic       linePulse_r;
  logic       polarity_r;
  logic       lineStart_r;
  logic       boost_r;

  wire       srcEn    = srcTick && (srcSelect != lcd_pkg::SRC_OFF);
  wire       runTick  = srcEn && driverOn;
  wire [2:0] divCnt_nxt = divCnt_r + 3'h1;
  wire       lineWrap = runTick && (divCnt_r == lcd_pkg::CL_CNT_LAST);
  wire       frameWrap = lineWrap && (lineIdx_r == lcd_pkg::COM_LAST);

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      divCnt_r    <= lcd_pkg::CNT_RESET;
      lineIdx_r   <= lcd_pkg::LINE_RESET;
      linePulse_r <= 1'b0;
      polarity_r  <= 1'b0;
      lineStart_r <= 1'b0;
      boost_r     <= 1'b0;
    end else begin
      boost_r     <= srcEn;
      lineStart_r <= lineWrap;
      if (!driverOn) begin
        divCnt_r    <= lcd_pkg::CNT_RESET;
        lineIdx_r   <= lcd_pkg::LINE_RESET;
        linePulse_r <= 1'b0;
      end else if (runTick) begin
        divCnt_r    <= divCnt_nxt;
        linePulse_r <= divCnt_nxt[lcd_pkg::CL_HIGH_BIT];
        if (lineWrap) begin
          lineIdx_r <= lineIdx_r + 6'h01;
        end
        if (frameWrap) begin
          polarity_r <= ~polarity_r;
        end
      end
    end
  end

  assign linePulse      = linePulse_r;
  assign polarityToggle = polarity_r;
  assign lineStart      = lineStart_r;
  assign lineIdx        = lineIdx_r;
  assign boostTick      = boost_r;

  property p_off_stops;
    @(posedge sys_clk) disable iff (!rstn)
      (srcSelect == lcd_pkg::SRC_OFF) |=> !boostTick && $stable(polarityToggle);
  endproperty
  a_off_stops: assert property (p_off_stops) else $error("Source off still ticks");

  property p_driver_off_quiet;
    @(posedge sys_clk) disable iff (!rstn)
      (!driverOn ##1 !driverOn) |-> !linePulse && $stable(polarityToggle);
  endproperty
  a_driver_off_quiet: assert property (p_driver_off_quiet) else $error("Signals run while off");

  property p_frame_edge;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(polarityToggle) |-> lineIdx == 6'h00 && $past(lineIdx) == 6'h3F;
  endproperty
  a_frame_edge: assert property (p_frame_edge) else $error("Polarity moved mid frame");

  property p_line_edge;
    @(posedge sys_clk) disable iff (!rstn)
      $changed(lineIdx) && $past(driverOn) |-> $past(divCnt_r) == 3'h7 && $rose(lineStart);
  endproperty
  a_line_edge: assert property (p_line_edge) else $error("Line advanced off count");

endmodule // lcd_timing_gen
